// [src/lsca_pkg.sv]
// Package: register map, field layout, reset values and timing of the light sensor block
package lsca_pkg;

  // System clock and the serial clock rates it must resolve
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned SCL_SMBUS_HZ = 100_000;
  localparam int unsigned SCL_FAST_HZ  = 400_000;
  // Shortest legal serial clock period in system clocks, rounded up
  localparam int unsigned SCL_SMB_CYC  = (CLK_HZ + SCL_SMBUS_HZ - 1) / SCL_SMBUS_HZ;
  localparam int unsigned SCL_FM_CYC   = (CLK_HZ + SCL_FAST_HZ - 1) / SCL_FAST_HZ;
  // Slack for synchroniser jitter on both edges of a period
  localparam int unsigned SCL_TOL      = 4;

  // Avalon byte address width and register byte offsets
  localparam int unsigned AV_AW       = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_INTEG   = 8'h04;
  localparam logic [7:0]  REG_THR_LO  = 8'h08;
  localparam logic [7:0]  REG_THR_HI  = 8'h0C;
  localparam logic [7:0]  REG_PERSIST = 8'h10;
  localparam logic [7:0]  REG_DATA    = 8'h14;
  localparam logic [7:0]  REG_STATUS  = 8'h18;
  localparam logic [7:0]  REG_MASK    = 8'h1C;
  localparam logic [7:0]  REG_INFO    = 8'h20;

  // Control fields
  localparam int unsigned CTRL_W     = 3;
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_ALERT = 1;
  localparam int unsigned CTRL_INTEN = 2;

  // Status and mask fields
  localparam int unsigned ST_W    = 3;
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_THR  = 1;
  localparam int unsigned ST_OVS  = 2;

  // Info fields
  localparam int unsigned INFO_BUSY    = 0;
  localparam int unsigned INFO_ADDR_OK = 1;
  localparam int unsigned INFO_ADDR    = 8;

  // Reset values
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [31:0] INTEG_RST  = 32'h0000_2710;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hFFFF;
  localparam logic [3:0]  PERS_RST   = 4'h0;

  // Serial slave addresses picked by the select pin, and the alert response address
  localparam logic [6:0]  ADDR_LOW   = 7'h20;
  localparam logic [6:0]  ADDR_FLOAT = 7'h30;
  localparam logic [6:0]  ADDR_HIGH  = 7'h40;
  localparam logic [6:0]  SMB_ARA    = 7'h0C;
  // Cycles after reset release before the select pin is captured
  localparam logic [1:0]  ADDR_CAP_CYC = 2'h3;

  // Conversion sequencer and serial slave states
  typedef enum logic [1:0] {C_IDLE, C_INTEG, C_XFER} lsca_conv_e;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WBYTE, I_WACK, I_RBYTE, I_RACK
  } lsca_i2c_e;

endpackage

// [src/lsca_link_if.sv]
// Interface between the sensor core and its serial slave
interface lsca_link_if;
  logic [6:0]  own_addr;     // Captured slave address
  logic        alert_req;    // Alert pending, answerable on the response address
  logic        smbus_mode;   // Alert style and 100 kHz limit
  logic [31:0] rd_data;      // Both channel results in one word
  logic        alert_taken;  // Pulse: alert response byte sent
  logic        clr_int;      // Pulse: host wrote to own address
  logic        overspeed;    // Pulse: serial clock faster than allowed
  modport ctrl (output own_addr, alert_req, smbus_mode, rd_data,
                input  alert_taken, clr_int, overspeed);
  modport serial (input  own_addr, alert_req, smbus_mode, rd_data,
                  output alert_taken, clr_int, overspeed);
endinterface

// [src/lsca_i2c_slave.sv]
// Two-wire serial slave: result reads, interrupt clear and alert response
module lsca_i2c_slave (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   scl,
  input  wire logic   sda_in,
  output logic        sda_oe,
  lsca_link_if.serial lnk
);
  import lsca_pkg::*;

  logic [2:0]  scl_q;        // [0] feeds only [1]
  logic [2:0]  sda_q;        // [0] feeds only [1]
  lsca_i2c_e   state;        // Protocol position
  logic [7:0]  shreg;        // Shift register, in and out
  logic [2:0]  bitcnt;       // Bit within byte
  logic        full;         // Eight bits received
  logic        rw;           // Read transfer
  logic        ara;          // Transfer is an alert response
  logic        nack;         // Master refused further bytes
  logic [1:0]  bytesel;      // Byte of snapshot being sent
  logic [31:0] snap;         // Results frozen at address ack
  logic [15:0] per_cnt;      // Cycles since last serial clock rise
  logic        clr_q;
  logic        taken_q;
  logic        ovs_q;

  // Byte lanes of the result word, low byte of channel 0 first
  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] s);
    pick = w[{s, 3'h0} +: 8];
  endfunction

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_c  = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire stop_c   = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  wire hit_own  = shreg[7:1] == lnk.own_addr;
  wire hit_ara  = (shreg[7:1] == SMB_ARA) & shreg[0] & lnk.alert_req;
  wire [7:0] first_byte = hit_ara ? {lnk.own_addr, 1'b0} : pick(lnk.rd_data, 2'h0);
  wire [7:0] nxt_byte   = ara ? 8'hFF : pick(snap, bytesel + 2'h1);
  wire [15:0] per_min   = lnk.smbus_mode ? 16'(SCL_SMB_CYC) : 16'(SCL_FM_CYC);

  assign lnk.clr_int     = clr_q;
  assign lnk.alert_taken = taken_q;
  assign lnk.overspeed   = ovs_q;

  // Pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // Period watch: a clock faster than the variant allows is flagged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt <= 16'hFFFF;
      ovs_q   <= 1'b0;
    end else begin
      ovs_q   <= scl_rise && (32'(per_cnt) + 32'(SCL_TOL) + 32'h1 < 32'(per_min)); // [R6]
      per_cnt <= scl_rise ? 16'h0000 : (per_cnt == 16'hFFFF ? per_cnt : per_cnt + 16'h1);
    end
  end

  // Protocol engine; data moves on the synchronised falling edge of the clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= I_IDLE; shreg <= 8'h00; bitcnt <= 3'h0; full <= 1'b0;
      rw <= 1'b0; ara <= 1'b0; nack <= 1'b0; bytesel <= 2'h0;
      snap <= 32'h0000_0000; sda_oe <= 1'b0; clr_q <= 1'b0; taken_q <= 1'b0;
    end else begin
      clr_q   <= 1'b0;
      taken_q <= 1'b0;
      if (start_c) begin
        state <= I_ADDR; bitcnt <= 3'h0; full <= 1'b0; sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= I_IDLE; sda_oe <= 1'b0;
      end else begin
        if (scl_rise && (state == I_ADDR || state == I_WBYTE)) begin
          shreg  <= {shreg[6:0], sda_q[1]};
          bitcnt <= bitcnt + 3'h1;
          full   <= bitcnt == 3'h7;
        end
        case (state)
          I_IDLE: ;
          I_ADDR: if (scl_fall && full) begin
            full <= 1'b0;
            if (hit_own || hit_ara) begin               // [R13]
              sda_oe  <= 1'b1;
              state   <= I_AACK;
              rw      <= shreg[0];
              ara     <= hit_ara;                       // [R11]
              snap    <= lnk.rd_data;                   // [R3]
              shreg   <= first_byte;
              bytesel <= 2'h0;
              clr_q   <= hit_own & ~shreg[0];           // [R10]
            end else begin
              state <= I_IDLE;
            end
          end
          I_AACK: if (scl_fall) begin
            bitcnt <= 3'h0;
            sda_oe <= rw & ~shreg[7];
            state  <= rw ? I_RBYTE : I_WBYTE;
          end
          I_WBYTE: if (scl_fall && full) begin
            full <= 1'b0; sda_oe <= 1'b1; state <= I_WACK;
          end
          I_WACK: if (scl_fall) begin
            sda_oe <= 1'b0; bitcnt <= 3'h0; state <= I_WBYTE;
          end
          I_RBYTE: if (scl_fall) begin
            if (bitcnt == 3'h7) begin
              sda_oe <= 1'b0; state <= I_RACK;
            end else begin
              bitcnt <= bitcnt + 3'h1;
              shreg  <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              nack    <= sda_q[1];
              taken_q <= ara & (bytesel == 2'h0);       // [R11]
            end
            if (scl_fall) begin
              if (nack) begin
                state <= I_IDLE;
              end else begin
                bytesel <= bytesel + 2'h1;
                shreg   <= nxt_byte;
                sda_oe  <= ~nxt_byte[7];
                bitcnt  <= 3'h0;
                state   <= I_RBYTE;
              end
            end
          end
          default: state <= I_IDLE;
        endcase
      end
    end
  end

endmodule

// [src/lsca_sensor.sv]
// Light sensor core: dual-channel integration, thresholds, interrupt and register slave
// How it works
// R1: Both channels integrate over one window
// R2: Broadband to data 0, infrared to 1
// R3: Results move whole, never half-updated
// R4: Next integration starts right after transfer
// R5: Each channel result is 16 bits
// R6: Serial link limited to 100/400 kHz
// R7: Host programs upper and lower thresholds
// R8: Interrupt when result leaves the band
// R9: Persistence count gates threshold interrupt
// R10: Level interrupt holds until host clears
// R11: SMBus variant signals alert style
// R12: Interrupt pin only ever pulls low
// R13: Three-state select pin picks address
// R14: Host reads, clears, then awaits next
module lsca_sensor (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic [lsca_pkg::AV_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            irq,
  input  wire logic                       pd0_pulse,
  input  wire logic                       pd1_pulse,
  input  wire logic                       addr_sel_hi,
  input  wire logic                       addr_sel_lo,
  input  wire logic                       scl,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  output logic                            int_out,
  output logic                            int_oe
);
  import lsca_pkg::*;

  // Software-written registers
  logic [CTRL_W-1:0] ctrl;       // Enable, alert style, pin enable
  logic [31:0]       integ_len;  // Integration window in clocks
  logic [15:0]       thr_lo;     // Lower limit
  logic [15:0]       thr_hi;     // Upper limit
  logic [3:0]        persist;    // Out-of-range conversions needed
  logic [ST_W-1:0]   status;     // Sticky events
  logic [ST_W-1:0]   mask;       // Events routed to irq

  // Conversion state
  lsca_conv_e        cstate;     // Sequencer state
  lsca_conv_e        next_cstate;
  logic [31:0]       icnt;       // Clocks elapsed in window
  logic [15:0]       acc [2];    // Running counts, one per channel
  logic [15:0]       data0;      // Broadband result
  logic [15:0]       data1;      // Infrared result
  logic [3:0]        miss;       // Consecutive out-of-range results
  logic              alert_req;  // Alert awaiting response

  // Pin capture
  logic [2:0]        pd_q [2];   // Pulse synchronisers, [0] feeds only [1]
  logic [1:0]        sel_hi_q;   // Select pin high sense
  logic [1:0]        sel_lo_q;   // Select pin low sense
  logic [6:0]        own_addr;   // Slave address in use
  logic              addr_done;  // Select pin has been captured
  logic [1:0]        cap_cnt;    // Wait for synchronisers to fill

  lsca_link_if lnk ();

  // Merge write data into an old value under the byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    wmerge = (old & ~m) | (wd & m);
  endfunction

  // Bus decode; a request is honoured at the edge that sees waitrequest low
  wire [7:0]  wa     = {avs_address[AV_AW-1:2], 2'b00};
  wire        req    = avs_read | avs_write;
  wire        wr_now = avs_write & ~avs_waitrequest;
  wire        wr_ctrl = wr_now && (wa == REG_CTRL);
  wire        wr_intg = wr_now && (wa == REG_INTEG);
  wire        wr_tlo  = wr_now && (wa == REG_THR_LO);
  wire        wr_thi  = wr_now && (wa == REG_THR_HI);
  wire        wr_per  = wr_now && (wa == REG_PERSIST);
  wire        wr_st   = wr_now && (wa == REG_STATUS);
  wire        wr_msk  = wr_now && (wa == REG_MASK);

  // Merged write values; narrow registers keep their low bits only
  wire [31:0] m_ctrl = wmerge({29'h0, ctrl}, avs_writedata, avs_byteenable);
  wire [31:0] m_intg = wmerge(integ_len, avs_writedata, avs_byteenable);
  wire [31:0] m_tlo  = wmerge({16'h0, thr_lo}, avs_writedata, avs_byteenable);
  wire [31:0] m_thi  = wmerge({16'h0, thr_hi}, avs_writedata, avs_byteenable);
  wire [31:0] m_per  = wmerge({28'h0, persist}, avs_writedata, avs_byteenable);
  wire [31:0] m_msk  = wmerge({29'h0, mask}, avs_writedata, avs_byteenable);
  wire [31:0] m_w1c  = wmerge(32'h0, avs_writedata, avs_byteenable);

  // Conversion decode
  wire        en        = ctrl[CTRL_EN];
  wire        in_window = cstate == C_INTEG;
  wire        xfer      = cstate == C_XFER;
  wire        integ_end = in_window && (icnt + 32'h1 >= integ_len);
  wire [1:0]  pd_in     = {pd1_pulse, pd0_pulse};
  wire [1:0]  pd_edge;

  // Threshold and persistence decode on the broadband count being transferred
  wire        out_rng  = (acc[0] < thr_lo) || (acc[0] > thr_hi);            // [R7] [R8]
  wire [3:0]  need     = (persist == 4'h0) ? 4'h1 : persist;
  wire        thr_fire = xfer && out_rng && ({1'b0, miss} + 5'h01 >= {1'b0, need}); // [R9]

  // Event sources and clears; a set in the same cycle as a clear wins
  wire [ST_W-1:0] st_set  = {lnk.overspeed, thr_fire, xfer};
  wire [ST_W-1:0] i2c_clr = ST_W'(lnk.clr_int) << ST_THR;
  wire [ST_W-1:0] st_clr  = (wr_st ? m_w1c[ST_W-1:0] : {ST_W{1'b0}}) | i2c_clr;
  wire            thr_clr = st_clr[ST_THR] | lnk.alert_taken;

  // Select pin decode: floating reads neither sense line
  wire [6:0]  sel_addr = sel_hi_q[1] ? ADDR_HIGH : (sel_lo_q[1] ? ADDR_LOW : ADDR_FLOAT);

  // Read multiplexer; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (wa)
      REG_CTRL:    rd_mux = {29'h0, ctrl};
      REG_INTEG:   rd_mux = integ_len;
      REG_THR_LO:  rd_mux = {16'h0, thr_lo};
      REG_THR_HI:  rd_mux = {16'h0, thr_hi};
      REG_PERSIST: rd_mux = {28'h0, persist};
      REG_DATA:    rd_mux = {data1, data0};   // Both channels in one access [R3]
      REG_STATUS:  rd_mux = {29'h0, status};
      REG_MASK:    rd_mux = {29'h0, mask};
      REG_INFO: begin
        rd_mux = 32'h0;
        rd_mux[INFO_BUSY]            = in_window;
        rd_mux[INFO_ADDR_OK]         = addr_done;
        rd_mux[INFO_ADDR +: 7]       = own_addr;
      end
      default:     rd_mux = 32'h0;
    endcase
  end

  // Link to the serial slave
  assign lnk.own_addr   = own_addr;
  assign lnk.alert_req  = alert_req & ctrl[CTRL_ALERT];
  assign lnk.smbus_mode = ctrl[CTRL_ALERT];                  // [R6]
  assign lnk.rd_data    = {data1, data0};

  // Avalon handshake: one wait state, then waitrequest low for one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= CTRL_RST;
      integ_len <= INTEG_RST;
      thr_lo    <= THR_LO_RST;
      thr_hi    <= THR_HI_RST;
      persist   <= PERS_RST;
      mask      <= {ST_W{1'b0}};
    end else begin
      if (wr_ctrl) ctrl <= m_ctrl[CTRL_W-1:0];
      if (wr_intg) integ_len <= m_intg;
      if (wr_tlo)  thr_lo <= m_tlo[15:0];      // [R7]
      if (wr_thi)  thr_hi <= m_thi[15:0];      // [R7]
      if (wr_per)  persist <= m_per[3:0];      // [R9]
      if (wr_msk)  mask <= m_msk[ST_W-1:0];
    end
  end

  // Sequencer: idle until enabled, then window, transfer, window again
  always_comb begin
    case (cstate)
      C_IDLE:  next_cstate = en ? C_INTEG : C_IDLE;
      C_INTEG: next_cstate = !en ? C_IDLE : (integ_end ? C_XFER : C_INTEG);
      C_XFER:  next_cstate = en ? C_INTEG : C_IDLE;          // [R4]
      default: next_cstate = C_IDLE;
    endcase
  end

  // Window counter runs only inside the window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cstate <= C_IDLE;
      icnt   <= 32'h0;
    end else begin
      cstate <= next_cstate;
      icnt   <= (next_cstate == C_INTEG && in_window) ? icnt + 32'h1 : 32'h0;
    end
  end

  // One counter per channel, both gated by the same window
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // Pulse synchroniser; the edge looks at the second and third stages only
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) pd_q[g] <= 3'h0;
        else pd_q[g] <= {pd_q[g][1:0], pd_in[g]};
      end
      assign pd_edge[g] = pd_q[g][1] & ~pd_q[g][2];
      // Saturating count; pulses in the transfer cycle are not counted
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          acc[g] <= 16'h0;
        end else if (!in_window) begin
          acc[g] <= 16'h0;                                   // [R1]
        end else if (pd_edge[g] && acc[g] != 16'hFFFF) begin
          acc[g] <= acc[g] + 16'h1;                          // [R1] [R5]
        end
      end
    end
  endgenerate

  // Results change only in the transfer cycle, both together; the counters
  // keep running in separate storage so a read never sees a partial value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data0 <= 16'h0;
      data1 <= 16'h0;
    end else if (xfer) begin
      data0 <= acc[0];                                       // [R2] [R3]
      data1 <= acc[1];                                       // [R2] [R3]
    end
  end

  // Persistence: consecutive out-of-range results, restarted after firing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      miss <= 4'h0;
    end else if (xfer) begin
      if (!out_rng || thr_fire) miss <= 4'h0;                // [R9]
      else if (miss != 4'hF) miss <= miss + 4'h1;
    end
  end

  // Sticky status and the alert latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status    <= {ST_W{1'b0}};
      alert_req <= 1'b0;
    end else begin
      status    <= (status & ~st_clr) | st_set;              // [R10]
      alert_req <= thr_fire | (alert_req & ~thr_clr);        // [R11]
    end
  end

  // Pin outputs: the data level is always low, only the enable moves.
  // Level style follows the sticky bit; alert style drops after the response.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
      sda_out <= 1'b0;
      irq     <= 1'b0;
    end else begin
      int_out <= 1'b0;                                       // [R12]
      int_oe  <= ctrl[CTRL_INTEN] &
                 (ctrl[CTRL_ALERT] ? alert_req : status[ST_THR]); // [R10] [R11] [R12]
      sda_out <= 1'b0;
      irq     <= |(status & mask);
    end
  end

  // Select pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_hi_q <= 2'h0;
      sel_lo_q <= 2'h0;
    end else begin
      sel_hi_q <= {sel_hi_q[0], addr_sel_hi};
      sel_lo_q <= {sel_lo_q[0], addr_sel_lo};
    end
  end

  // Address is caught once after reset release, when the synchronisers hold
  // real pin levels; later pin changes are ignored until the next reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_cnt   <= 2'h0;
      addr_done <= 1'b0;
      own_addr  <= ADDR_FLOAT;
    end else if (!addr_done) begin
      if (cap_cnt == ADDR_CAP_CYC) begin
        addr_done <= 1'b1;
        own_addr  <= sel_addr;                               // [R13]
      end else begin
        cap_cnt <= cap_cnt + 2'h1;
      end
    end
  end

  // Serial slave; its data pin enable is a flip-flop inside it
  lsca_i2c_slave u_serial (
    .clk    (clk),
    .resetn (resetn),
    .scl    (scl),
    .sda_in (sda_in),
    .sda_oe (sda_oe),
    .lnk    (lnk)
  );

endmodule

// [tb/lsca_sensor_assertions.sv]
// Checker: bus handshake, read data hold and open-drain pin relations
module lsca_sensor_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        scl,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        int_out,
  input wire logic        int_oe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  data_hold_a: assert property (!$past(avs_waitrequest && (avs_read || avs_write))
    |-> $stable(avs_readdata)) else $error("read data moved");
  int_low_a: assert property (int_out == 1'b0) else $error("int driven high");
  sda_low_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  ack_start_a: assert property ($rose(sda_oe) |-> !scl)
    else $error("sda taken while clock high");
  ack_end_a: assert property ($fell(sda_oe) |-> !scl)
    else $error("sda released while clock high");
  cover property ($rose(irq));
  cover property ($rose(int_oe));
  cover property ($rose(sda_oe));
endmodule
bind lsca_sensor lsca_sensor_chk lsca_sensor_chk_inst (.clk, .resetn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .scl, .sda_out, .sda_oe, .int_out, .int_oe, .irq);

// [tb/lsca_host_model.sv]
// Far side: light pulse source and serial host on a pulled-up data line
module lsca_host_model (
  output logic      pd0,
  output logic      pd1,
  output logic      scl,
  output logic      sda_h,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: dark, clock and data released
  initial begin
    {pd0, pd1, scl, sda_h} = 4'h3;
  end
  // Both channels pulse in one span; 30 ns levels clear the synchroniser
  task automatic burst(input int n0, input int n1);
    for (int i = 0; i < 20; i++) begin
      {pd0, pd1} = {i < n0, i < n1};
      #30;
      {pd0, pd1} = 2'h0;
      #30;
    end
  endtask
  // Address frame then STOP; the clock stands still outside it
  task automatic frame(input logic [7:0] b, output logic ack);
    logic [7:0] sh;
    sh = b;
    sda_h = 1'b0;
    #62.5;
    for (int i = 0; i < 9; i++) begin
      scl = 1'b0;
      #31;
      sda_h = sh[7];
      sh = {sh[6:0], 1'b1};
      #31.5;
      scl = 1'b1;
      ack = !sda;
      #62.5;
    end
    scl = 1'b0;
    #31;
    sda_h = 1'b0;
    #31.5;
    scl = 1'b1;
    #31;
    sda_h = 1'b1;
  endtask
endmodule

// [tb/tb.sv]
// Bench: register traffic, conversion bursts, interrupts and serial frames
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lsca_pkg::*;
  logic        clk, resetn, rd, wr, ack;
  logic [7:0]  adr;
  logic [15:0] n0, n1;
  logic [31:0] wd, lf;
  logic [31:0] expq[$];
  int          error_cnt, n_tests;
  wire  [31:0] rdata;
  wire         wrq, irq, pd0, pd1, scl, sda_h, sda_oe, sda_out, int_out, int_oe;
  wire         sda = sda_h & !sda_oe;  // Pull-up: low while anyone pulls
  lsca_sensor lsca_sensor_inst (.clk, .resetn, .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wrq), .irq, .pd0_pulse(pd0), .pd1_pulse(pd1), .addr_sel_hi(1'b0),
    .addr_sel_lo(1'b1), .scl, .sda_in(sda), .sda_out, .sda_oe, .int_out, .int_oe);
  lsca_host_model lsca_host_model_inst (.pd0, .pd1, .scl, .sda_h, .sda);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One access, held until waitrequest is seen low; a bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      end_of_test();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    int k;
    @(posedge clk);  // A status clear reaches irq one edge late
    for (k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge clk);
    if (k == 5000) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // Scoreboard: each read answer against the oldest note
  always @(posedge clk) begin
    if (rd && wrq === 1'b0) check("readdata", rdata, expq.pop_front());
  end
  initial begin
    {resetn, rd, wr, adr, wd} = '0;
    lf = 32'h7E3A;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
    rdx(REG_INFO, {17'h0, ADDR_LOW, 8'h02});
    rdx(REG_THR_HI, 32'h0000FFFF);
    rdx(8'h40, 32'h0);
    $display("test reset values done");
    bus(1'b1, REG_INTEG, 32'h190);
    bus(1'b1, REG_MASK, 32'h1);
    bus(1'b1, REG_CTRL, 32'h5);
    // Equal to the upper limit stays in band, one above it fires
    for (int t = 0; t < 2; t++) begin
      lf = nx(lf);
      n0 = 16'h4 + 16'(lf[3:0]);
      n1 = 16'h4 + 16'(lf[7:4]);
      bus(1'b1, REG_THR_HI, 32'(n0 - 16'(t)));
      bus(1'b1, REG_STATUS, 32'h7);
      wait_irq();
      bus(1'b1, REG_STATUS, 32'h1);
      lsca_host_model_inst.burst(n0, n1);
      wait_irq();
      rdx(REG_DATA, {n1, n0});
      rdx(REG_STATUS, 32'h1 | 32'(t << 1));
      check("int_oe", 32'(int_oe), 32'(t));
      $display("test conversion %0d done", t);
    end
    bus(1'b1, REG_CTRL, 32'h4);
    lsca_host_model_inst.frame({ADDR_LOW, 1'b0}, ack);
    check("ack", 32'(ack), 32'h1);
    repeat (4) @(posedge clk);
    check("int_oe", 32'(int_oe), 32'h0);
    rdx(REG_STATUS, 32'h5);
    lsca_host_model_inst.frame({ADDR_FLOAT, 1'b0}, ack);
    check("ack", 32'(ack), 32'h0);
    // Alert style: re-arm the latch, then answer on the response address
    bus(1'b1, REG_STATUS, 32'h7);
    bus(1'b1, REG_CTRL, 32'h7);
    lsca_host_model_inst.burst(n0, n1);
    wait_irq();
    bus(1'b1, REG_CTRL, 32'h6);
    check("int_oe", 32'(int_oe), 32'h1);
    lsca_host_model_inst.frame({SMB_ARA, 1'b1}, ack);
    check("ack", 32'(ack), 32'h1);
    $display("test serial done");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
